// ===== rtl/sarq_pkg.sv
// Purpose: Shared constants and types of the converter acquire/convert sequencer.
// Assumes: A 40 MHz system clock; the analog front end sits outside this logic.
// Notes: Timing counts are derived from times given in nanoseconds.
package sarq_pkg;

  // System clock and internal converter clock.
  localparam int CLK_PERIOD_NS = 25;
  localparam int INT_CLK_PERIOD_NS = 250;
  localparam int INT_CLK_CYCLES = INT_CLK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [3:0] INT_DIV_LAST = 4'(INT_CLK_CYCLES - 1);

  // Converter clock tick counts.
  localparam logic [3:0] ACQ_LAST_TICK = 4'h3;
  localparam logic [3:0] CONV_TICKS = 4'hD;
  localparam logic [3:0] CONV_DONE_CYC = 4'hC;
  localparam logic [3:0] BIT_FIRST_CYC = 4'h1;
  localparam logic [3:0] BIT_LAST_CYC = 4'hA;
  localparam int RESULT_W = 10;
  localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;

  // Control byte fields.
  localparam int CB_PD1 = 7;
  localparam int CB_PD0 = 6;
  localparam int CB_ACQ = 5;
  localparam int CB_CFG = 4;
  localparam int CB_BIP = 3;
  localparam logic [7:0] CTRL_BYTE_RESET = 8'hC0;

  // Register offsets on the APB side.
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_RESULT = 12'h004;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h008;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h00C;
  localparam logic [11:0] OFS_CONFIG = 12'h010;

  // Interrupt bits and reset values.
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ABORT = 1;
  localparam int IRQ_WRITE = 2;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  localparam logic CONFIG_PORT_EN_RESET = 1'b1;

  // Pin synchroniser layout: cs_n, wr_n, rd_n, upper, ext clock, comparator, data.
  localparam int SYNC_W = 14;
  localparam logic [13:0] SYNC_RESET = 14'h3800;

  typedef enum logic [2:0] {
    SARQ_IDLE = 3'b000,
    SARQ_TRACK_EXT = 3'b001,
    SARQ_TRACK_INT = 3'b010,
    SARQ_CONVERT = 3'b011
  } sarq_state_t;

endpackage : sarq_pkg

// ===== rtl/sarq_sar_engine.sv
// Purpose: Successive-approximation bit trials over thirteen converter clock ticks.
// Assumes: tick is a one-cycle pulse already qualified by the clock enable.
// Notes: comp_high high means the held sample is above the trial code.
`timescale 1ns/100ps
module sarq_sar_engine (
  input wire logic clk,
  input wire logic clk_en,
  input wire logic reset,
  input wire logic start,
  input wire logic abort,
  input wire logic tick,
  input wire logic comp_high,
  output logic busy,
  output logic neg_switched,
  output logic [9:0] dac_code,
  output logic [9:0] result,
  output logic done
);
  import sarq_pkg::*;

  logic [3:0] cyc;
  wire [3:0] bit_pos = 4'(BIT_LAST_CYC - cyc);
  wire in_trials = (cyc >= BIT_FIRST_CYC) && (cyc <= BIT_LAST_CYC);
  wire step = busy && tick;

  always_ff @(posedge clk) begin
    if (reset) begin
      busy <= 1'b0;
      cyc <= 4'h0;
      dac_code <= 10'h000;
      result <= 10'h000;
      done <= 1'b0;
      neg_switched <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
        neg_switched <= 1'b0;
      end else if (start) begin
        busy <= 1'b1;
        cyc <= 4'h0;
        dac_code <= SAR_FIRST_TRIAL;
        neg_switched <= 1'b0;
      end else if (step) begin
        cyc <= cyc + 4'h1;
        if (cyc == 4'h0) begin
          neg_switched <= 1'b1;
        end
        if (in_trials) begin
          if (!comp_high) begin
            dac_code[bit_pos] <= 1'b0;
          end
          if (bit_pos != 4'h0) begin
            dac_code[bit_pos - 4'h1] <= 1'b1;
          end
        end
        if (cyc == CONV_DONE_CYC) begin
          busy <= 1'b0;
          done <= 1'b1;
          result <= dac_code;
          neg_switched <= 1'b0;
        end
      end
    end
  end

endmodule : sarq_sar_engine

// ===== rtl/sarq_sequencer.sv
// Purpose: Acquire/convert sequencer with byte-wide host port and APB status side.
// Assumes: Host pins are asynchronous and pass two flip-flops before use.
// Notes: Converter clock edges are treated as one-cycle ticks of the system clock.
// Functional notes
// - Qualified store strobe rise starts tracking.
// - External mode: next store rise holds.
// - Internal mode: hold on fourth falling tick.
// - Conversion lasts exactly thirteen converter clocks.
// - Write during conversion aborts, restarts acquisition.
// - Mode bit picks acquisition only or both.
// - Sample taken as acquisition interval ends.
// - Conversion start moves capacitor to return.
// - Single-ended: channel positive, zero reference negative.
// - Pseudo-differential: both nodes from pair.
// - Ten-bit result over byte port, split.
// - Done flag low on completion, released.
// - Upper select picks two MSBs, else eight.
// - Fetch strobe with select drives bus.
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
module sarq_sequencer #(
  parameter bit FOUR_CHANNEL = 1'b0
) (
  input wire logic clk,
  input wire logic clk_en,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic upper_byte_select,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  output logic int_n,
  input wire logic ext_conv_clk,
  input wire logic comp_high,
  output logic sample_hold,
  output logic hold_cap_to_neg,
  output logic [2:0] mux_pos_sel,
  output logic [2:0] mux_neg_sel,
  output logic mux_neg_is_zero_ref,
  output logic bipolar_mode,
  output logic [9:0] dac_code,
  output logic irq
);
  import sarq_pkg::*;

  sarq_pkg::sarq_state_t state;
  sarq_pkg::sarq_state_t next_state;
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic wr_prev;
  logic rd_prev;
  logic ext_prev;
  logic [3:0] div_cnt;
  logic clk_mode_int;
  logic [7:0] ctrl_byte;
  logic [3:0] acq_ticks;
  logic [9:0] result;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic port_en;
  logic resp_valid;
  logic sar_busy;
  logic sar_done;
  logic [9:0] sar_result;

  // The first synchroniser stage feeds only the second one.
  wire cs_s = sync2[13];
  wire wr_s = sync2[12];
  wire rd_s = sync2[11];
  wire upper_s = sync2[10];
  wire ext_s = sync2[9];
  wire comp_s = sync2[8];
  wire [7:0] din_s = sync2[7:0];

  wire pin_write = clk_en && port_en && !cs_s && wr_s && !wr_prev;
  wire pin_read = clk_en && !cs_s && !rd_s && rd_prev;
  wire div_wrap = (div_cnt == INT_DIV_LAST);
  // A tick marks a falling converter clock edge.
  wire conv_tick = clk_en && (clk_mode_int ? div_wrap : (ext_prev && !ext_s));
  wire tracking = (state == SARQ_TRACK_EXT) || (state == SARQ_TRACK_INT);
  wire start_conv = clk_en && (next_state == SARQ_CONVERT) && (state != SARQ_CONVERT);
  wire abort_conv = pin_write && (state == SARQ_CONVERT);
  wire [2:0] chan = FOUR_CHANNEL ? {1'b0, ctrl_byte[1:0]} : ctrl_byte[2:0];

  always_ff @(posedge clk) begin
    if (reset) begin
      sync1 <= SYNC_RESET;
      sync2 <= SYNC_RESET;
      wr_prev <= 1'b1;
      rd_prev <= 1'b1;
      ext_prev <= 1'b0;
    end else if (clk_en) begin
      sync1 <= {cs_n, wr_n, rd_n, upper_byte_select, ext_conv_clk, comp_high, data_in};
      sync2 <= sync1;
      wr_prev <= wr_s;
      rd_prev <= rd_s;
      ext_prev <= ext_s;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      div_cnt <= 4'h0;
    end else if (clk_en) begin
      div_cnt <= div_wrap ? 4'h0 : div_cnt + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_byte <= CTRL_BYTE_RESET;
      clk_mode_int <= 1'b0;
    end else if (pin_write) begin
      ctrl_byte <= din_s;
      if (din_s[CB_PD1]) begin
        clk_mode_int <= !din_s[CB_PD0];
      end
    end
  end

  always_comb begin
    next_state = state;
    if (pin_write) begin
      if (din_s[CB_ACQ]) begin
        next_state = SARQ_TRACK_EXT;
      end else if (state == SARQ_TRACK_EXT) begin
        next_state = SARQ_CONVERT;
      end else begin
        next_state = SARQ_TRACK_INT;
      end
    end else begin
      unique case (state)
        SARQ_IDLE: next_state = SARQ_IDLE;
        SARQ_TRACK_EXT: next_state = SARQ_TRACK_EXT;
        SARQ_TRACK_INT: begin
          if (conv_tick && acq_ticks == ACQ_LAST_TICK) begin
            next_state = SARQ_CONVERT;
          end
        end
        SARQ_CONVERT: begin
          if (sar_done) begin
            next_state = SARQ_IDLE;
          end
        end
        default: next_state = SARQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= SARQ_IDLE;
      acq_ticks <= 4'h0;
    end else if (clk_en) begin
      state <= next_state;
      if (pin_write) begin
        acq_ticks <= 4'h0;
      end else if (state == SARQ_TRACK_INT && conv_tick) begin
        acq_ticks <= acq_ticks + 4'h1;
      end
    end
  end

  assign sample_hold = !tracking;
  assign mux_pos_sel = chan;
  assign mux_neg_sel = ctrl_byte[CB_CFG] ? 3'h0 : {chan[2:1], !chan[0]};
  assign mux_neg_is_zero_ref = ctrl_byte[CB_CFG];
  assign bipolar_mode = ctrl_byte[CB_BIP];

  sarq_sar_engine u_sar (
    .clk(clk),
    .clk_en(clk_en),
    .reset(reset),
    .start(start_conv),
    .abort(abort_conv),
    .tick(conv_tick),
    .comp_high(comp_s),
    .busy(sar_busy),
    .neg_switched(hold_cap_to_neg),
    .dac_code(dac_code),
    .result(sar_result),
    .done(sar_done)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      result <= 10'h000;
      data_out <= 8'h00;
      data_oe_n <= 1'b1;
    end else if (clk_en) begin
      if (sar_done) begin
        result <= sar_result;
      end
      data_out <= upper_s ? {6'h00, result[9:8]} : result[7:0];
      data_oe_n <= cs_s || rd_s;
    end
  end

  // Done flag, completion wins over release.
  always_ff @(posedge clk) begin
    if (reset) begin
      int_n <= 1'b1;
    end else if (clk_en) begin
      if (sar_done) begin
        int_n <= 1'b0;
      end else if (pin_read || pin_write) begin
        int_n <= 1'b1;
      end
    end
  end

  // APB slave with one wait state so read data comes from a flip-flop.
  wire apb_access = psel && penable;
  wire apb_take = apb_access && resp_valid;
  wire hit_status = (paddr == OFS_STATUS);
  wire hit_result = (paddr == OFS_RESULT);
  wire hit_irq_status = (paddr == OFS_IRQ_STATUS);
  wire hit_irq_mask = (paddr == OFS_IRQ_MASK);
  wire hit_config = (paddr == OFS_CONFIG);
  wire hit_any = hit_status || hit_result || hit_irq_status || hit_irq_mask || hit_config;
  wire apb_wr = clk_en && apb_take && pwrite && hit_any;
  wire [31:0] status_word = {18'h0, state, sar_busy, clk_mode_int, int_n, ctrl_byte};
  wire [31:0] read_word = hit_status ? status_word :
                          hit_result ? {22'h0, result} :
                          hit_irq_status ? {29'h0, irq_status} :
                          hit_irq_mask ? {29'h0, irq_mask} :
                          hit_config ? {31'h0, port_en} : 32'h0;
  wire [IRQ_W-1:0] irq_clr = (apb_wr && hit_irq_status) ? pwdata[IRQ_W-1:0] : 3'h0;
  wire [IRQ_W-1:0] irq_events = {pin_write, abort_conv, clk_en && sar_done};
  assign pready = apb_take;

  always_ff @(posedge clk) begin
    if (reset) begin
      resp_valid <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
      irq_mask <= IRQ_MASK_RESET;
      port_en <= CONFIG_PORT_EN_RESET;
      irq_status <= 3'h0;
    end else if (clk_en) begin
      resp_valid <= apb_access && !resp_valid;
      if (apb_access && !resp_valid) begin
        prdata <= pwrite ? 32'h0 : read_word;
        pslverr <= !hit_any;
      end
      if (apb_wr && hit_irq_mask) begin
        irq_mask <= pwdata[IRQ_W-1:0];
      end
      if (apb_wr && hit_config) begin
        port_en <= pwdata[0];
      end
      // A new event outweighs a clear in the same cycle.
      irq_status <= (irq_status & ~irq_clr) | irq_events;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Checking helpers.
  logic [3:0] conv_ticks;
  always_ff @(posedge clk) begin
    if (reset || start_conv) begin
      conv_ticks <= 4'h0;
    end else if (conv_tick && state == SARQ_CONVERT) begin
      conv_ticks <= conv_ticks + 4'h1;
    end
  end

  property p_track_on_write;
    @(posedge clk) disable iff (reset) pin_write && din_s[CB_ACQ] |=> !sample_hold;
  endproperty
  a_track_on_write: assert property (p_track_on_write) else $error("no tracking");
  property p_ext_hold;
    @(posedge clk) disable iff (reset)
      pin_write && !din_s[CB_ACQ] && state == SARQ_TRACK_EXT |=> sample_hold && sar_busy;
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("ext hold missed");
  property p_int_hold;
    @(posedge clk) disable iff (reset)
      state == SARQ_TRACK_INT && !pin_write && conv_tick && acq_ticks == ACQ_LAST_TICK
      |=> state == SARQ_CONVERT;
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("int hold late");
  property p_conv_len;
    @(posedge clk) disable iff (reset) sar_done |-> conv_ticks == CONV_TICKS;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("bad conversion length");
  property p_abort;
    @(posedge clk) disable iff (reset) abort_conv |=> !sar_busy && !sample_hold;
  endproperty
  a_abort: assert property (p_abort) else $error("abort failed");
  property p_neg_switch;
    @(posedge clk) disable iff (reset) $rose(hold_cap_to_neg) |-> $past(conv_tick) && sar_busy;
  endproperty
  a_neg_switch: assert property (p_neg_switch) else $error("switch untimed");
  property p_single_route;
    @(posedge clk) disable iff (reset)
      ctrl_byte[CB_CFG] |-> mux_neg_is_zero_ref && mux_neg_sel == 3'h0 && mux_pos_sel == chan;
  endproperty
  a_single_route: assert property (p_single_route) else $error("route wrong");
  property p_done_flag;
    @(posedge clk) disable iff (reset) clk_en && sar_done |=> !int_n;
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("done flag missed");
  property p_release;
    @(posedge clk) disable iff (reset) pin_read && !sar_done |=> int_n;
  endproperty
  a_release: assert property (p_release) else $error("flag not released");
  property p_latch;
    @(posedge clk) disable iff (reset)
      clk_en && sar_done |=> result == $past(sar_result) && !sar_busy;
  endproperty
  a_latch: assert property (p_latch) else $error("result not latched");
  property p_drive;
    @(posedge clk) disable iff (reset) clk_en && !cs_s && !rd_s |=> !data_oe_n;
  endproperty
  a_drive: assert property (p_drive) else $error("bus not driven");

  c_ext_conv: cover property (@(posedge clk) state == SARQ_TRACK_EXT ##[1:300] sar_done);
  c_int_conv: cover property (@(posedge clk) state == SARQ_TRACK_INT ##[1:500] sar_done);
  c_abort: cover property (@(posedge clk) abort_conv);

endmodule : sarq_sequencer

// ===== verification/sarq_host_model.sv
// Purpose: Host processor model driving the byte-wide converter port.
// Assumes: Strobes are held several clocks so the pin synchronisers see them.
// Notes: Data pins show the inverse of the last byte once the host lets go.
`timescale 1ns/100ps
module sarq_host_model (
  input wire logic clk,
  output logic cs_n,
  output logic wr_n,
  output logic rd_n,
  output logic upper_byte_select,
  output logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n
);
  initial begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    upper_byte_select = 1'b0;
    data_in = 8'h00;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask : hold
  task automatic write_byte(input logic [7:0] b, input logic sel_n);
    hold(1);
    cs_n <= sel_n;
    data_in <= b;
    hold(3);
    wr_n <= 1'b0;
    hold(4);
    wr_n <= 1'b1;
    hold(5);
    cs_n <= 1'b1;
    data_in <= ~b;
    hold(1);
  endtask : write_byte
  task automatic read_byte(input logic up, output logic [7:0] b, output logic oe_n);
    hold(1);
    upper_byte_select <= up;
    cs_n <= 1'b0;
    hold(2);
    rd_n <= 1'b0;
    hold(6);
    @(negedge clk);
    b = data_out;
    oe_n = data_oe_n;
    hold(1);
    rd_n <= 1'b1;
    cs_n <= 1'b1;
    hold(4);
  endtask : read_byte
endmodule : sarq_host_model

// ===== verification/test_sar_adc_acquire_convert_sequencer.sv
// Purpose: Self-checking bench for the acquire/convert sequencer.
// Assumes: The comparator model keeps a bit while the target is at or above the trial.
// Notes: The external converter clock is derived from clk, sixteen cycles a period.
`timescale 1ns/100ps
module test_sar_adc_acquire_convert_sequencer;
  import sarq_pkg::*;
  logic clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic cs_n, wr_n, rd_n, upper_byte_select, data_oe_n, int_n, clk_en;
  logic ext_conv_clk = 1'b0;
  logic comp_high = 1'b0;
  logic [7:0] data_in, data_out, b;
  logic sample_hold, hold_cap_to_neg, mux_neg_is_zero_ref, bipolar_mode, irq, er, oe;
  logic [2:0] mux_pos_sel, mux_neg_sel;
  logic [2:0] div = 3'h0;
  logic [9:0] dac_code, target;
  int num_errors, n_tests, n, e0;
  int ext_falls = 0;
  sarq_sequencer uut (.clk(clk), .clk_en(clk_en), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
    .upper_byte_select(upper_byte_select), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .int_n(int_n), .ext_conv_clk(ext_conv_clk),
    .comp_high(comp_high), .sample_hold(sample_hold), .hold_cap_to_neg(hold_cap_to_neg),
    .mux_pos_sel(mux_pos_sel), .mux_neg_sel(mux_neg_sel),
    .mux_neg_is_zero_ref(mux_neg_is_zero_ref), .bipolar_mode(bipolar_mode),
    .dac_code(dac_code), .irq(irq));
  sarq_host_model host (.clk(clk), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
    .upper_byte_select(upper_byte_select), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // The comparator answers from a register, as an analog stage would settle late.
  always @(posedge clk) begin
    div <= div + 3'h1;
    comp_high <= (dac_code <= target);
    if (div == 3'h7) begin
      ext_conv_clk <= ~ext_conv_clk;
      if (ext_conv_clk) ext_falls <= ext_falls + 1;
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk1(input string nm, input logic e, input logic g);
    chk(nm, 32'(e), 32'(g));
  endtask : chk1
  task automatic lim(input int i, input int m);
    if (i >= m) begin
      chk1("timeout", 1'b0, 1'b1);
      wrap_up();
    end
  endtask : lim
  function automatic logic cond(input int s);
    case (s)
      0: return int_n === 1'b0;
      1: return hold_cap_to_neg === 1'b1;
      default: return sample_hold === 1'b1;
    endcase
  endfunction : cond
  task automatic wait_on(input int s, output int c);
    for (c = 0; c < 2000 && !cond(s); c++) @(negedge clk);
    lim(c, 2000);
  endtask : wait_on
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20 && pready !== 1'b1; i++) @(negedge clk);
    lim(i, 20);
    @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Callers look at outputs only after this edge's updates have landed.
    @(negedge clk);
  endtask : apb
  task automatic t_reset();
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status", 32'h000001C0, rd);
    apb(1'b0, OFS_CONFIG, 32'h0);
    chk("config", 32'h1, rd);
    apb(1'b1, 12'h020, 32'h7);
    chk1("slverr", 1'b1, er);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", 32'h0, rd);
    host.write_byte(8'hF5, 1'b1);
    chk1("cs_refused", 1'b1, sample_hold);
    apb(1'b1, OFS_CONFIG, 32'h0);
    host.write_byte(8'hF5, 1'b0);
    chk1("port_off", 1'b1, sample_hold);
    apb(1'b1, OFS_CONFIG, 32'h1);
    apb(1'b0, OFS_IRQ_STATUS, 32'h0);
    chk("no_events", 32'h0, rd);
  endtask : t_reset
  task automatic t_ext();
    target = 10'h2B6;
    host.write_byte(8'hF5, 1'b0);
    chk1("track", 1'b0, sample_hold);
    chk("pos", 32'h5, 32'(mux_pos_sel));
    chk("neg0", 32'h0, 32'(mux_neg_sel));
    chk1("zref", 1'b1, mux_neg_is_zero_ref);
    repeat (60) @(negedge clk);
    chk1("still_track", 1'b0, sample_hold);
    @(posedge clk);
    clk_en <= 1'b0;
    host.write_byte(8'hD5, 1'b0);
    clk_en <= 1'b1;
    chk1("frozen", 1'b0, sample_hold);
    host.write_byte(8'hD5, 1'b0);
    wait_on(2, n);
    chk1("held", 1'b1, sample_hold);
    wait_on(1, n);
    e0 = ext_falls;
    wait_on(0, n);
    chk("ticks", 32'd12, 32'(ext_falls - e0));
    chk1("cap_back", 1'b0, hold_cap_to_neg);
    host.read_byte(1'b0, b, oe);
    chk("low", 32'hB6, 32'(b));
    chk1("oe", 1'b0, oe);
    chk1("oe_off", 1'b1, data_oe_n);
    chk1("int_rel", 1'b1, int_n);
  endtask : t_ext
  task automatic t_int();
    apb(1'b1, OFS_IRQ_STATUS, 32'h7);
    host.write_byte(8'h9A, 1'b0);
    chk1("bip", 1'b1, bipolar_mode);
    chk("pos2", 32'h2, 32'(mux_pos_sel));
    wait_on(2, n);
    chk1("acq_len", 1'b1, n >= 26 && n <= 40);
    wait_on(1, n);
    target = 10'h155;
    host.write_byte(8'h83, 1'b0);
    chk1("abort_cap", 1'b0, hold_cap_to_neg);
    chk1("abort_trk", 1'b0, sample_hold);
    chk("neg", 32'h2, 32'(mux_neg_sel));
    chk1("diff", 1'b0, mux_neg_is_zero_ref);
    apb(1'b0, OFS_IRQ_STATUS, 32'h0);
    chk("irq_abort", 32'h6, rd);
    chk1("masked", 1'b0, irq);
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("ctrl", 32'h83, 32'(rd[7:0]));
    wait_on(1, n);
    wait_on(0, n);
    chk1("conv_len", 1'b1, n >= 119 && n <= 122);
    chk1("irq_on", 1'b1, irq);
    host.read_byte(1'b1, b, oe);
    chk("up", 32'h1, 32'(b));
    host.read_byte(1'b0, b, oe);
    chk("low2", 32'h55, 32'(b));
    apb(1'b0, OFS_RESULT, 32'h0);
    chk("result_reg", 32'h155, rd);
    apb(1'b1, OFS_IRQ_STATUS, 32'h1);
    chk1("irq_clr", 1'b0, irq);
  endtask : t_int
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    clk_en = 1'b1;
    target = 10'h000;
    num_errors = 0;
    n_tests = 0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_ext();
    t_int();
    wrap_up();
  end
endmodule : test_sar_adc_acquire_convert_sequencer
